/* core/apf_consts.vh */
// Constants for the converter control block
`ifndef APF_CONSTS_VH
`define APF_CONSTS_VH
// Register byte offsets
`define APF_OFS_CTRL   8'h00
`define APF_OFS_CLK    8'h04
`define APF_OFS_PINCFG 8'h08
`define APF_OFS_PORT   8'h0c
`define APF_OFS_CHSEL  8'h10
`define APF_OFS_BUF    8'h40
`define APF_BUF_MASK   8'hc0
// Control register fields
`define APF_ON_BIT     15
`define APF_SIDL_BIT   13
`define APF_FORM_HI    9
`define APF_FORM_LO    8
`define APF_AUTO_BIT   2
`define APF_SAMPLE_CONTROL_BIT   1
`define APF_DONE_BIT   0
// Clock register fields
`define APF_SAMC_HI    12
`define APF_SAMC_LO    8
`define APF_RC_BIT     7
`define APF_DIV_HI     5
`define APF_DIV_LO     0
// Format codes
`define APF_FMT_INT    2'h0
`define APF_FMT_SINT   2'h1
`define APF_FMT_FRAC   2'h2
`define APF_FMT_SFRAC  2'h3
// Bus responses
`define APF_RESP_OK    2'h0
`define APF_RESP_ERR   2'h2
// Timing: conversion length in clock periods, instruction cycle in aclk cycles
`define APF_CONV_TADS  4'hc
`define APF_TCY_NS     8
`define APF_ACLK_NS    4
`define APF_TCY_CYC    (`APF_TCY_NS / `APF_ACLK_NS)
`endif

/* core/apf_ctrl.v */
// Converter control: power, sleep/idle, result formats, pin readback
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "apf_consts.vh"
module apf_ctrl #(
    parameter NPINS = 9,
    parameter DEPTH = 16
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // AXI4-Lite slave
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Device power state and interrupt enable
    input  wire              sleep_mode,
    input  wire              idle_mode,
    input  wire              irq_enable,
    // Pins and analog core
    input  wire [NPINS-1:0]  pin_in,
    input  wire              rc_osc_in,
    input  wire [9:0]        sar_result,
    // Analog control outputs, completion pulse and wake request
    output reg               analog_enable,
    output reg               rc_osc_enable,
    output reg               hold_capacitor_connect,
    output reg               conv_clk,
    output reg               irq_pulse,
    output reg               wake_req
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SAMPLE_CONTROL = 2'h1;
    localparam ST_DLY  = 2'h2;
    localparam ST_CONV = 2'h3;

    function [15:0] fmt_read;
        input [9:0] d;
        input [1:0] f;
        begin
            case (f)
                `APF_FMT_INT:  fmt_read = {6'h00, d};
                `APF_FMT_SINT: fmt_read = {{6{d[9]}}, d};
                default:       fmt_read = {d, 6'h00};
            endcase
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  st;
        begin
            merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // Registers
    reg              on_reg, sidl_reg, auto_reg, sample_control_reg, done_reg;
    reg  [1:0]       form_reg;
    reg  [4:0]       samc_reg;
    reg              rc_reg;
    reg  [5:0]       div_reg;
    reg  [NPINS-1:0] pcfg_reg, dir_reg;
    reg  [7:0]       chsel_reg;
    reg  [9:0]       buf_mem [0:DEPTH-1];
    reg  [3:0]       wptr_reg;
    reg  [1:0]       st_reg;
    reg  [5:0]       tad_cnt_reg;
    reg  [4:0]       seq_cnt_reg;
    reg  [1:0]       dly_reg;
    reg              pdown_reg, sleep_d_reg;
    reg  [2:0]       rc_sync_reg;
    reg  [NPINS-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_val_reg;

    // Synchronisers: a change counts once stages two and three agree
    always @(posedge aclk) begin
        rc_sync_reg <= {rc_sync_reg[1:0], rc_osc_in};
        pin_s1_reg  <= pin_in;
        pin_s2_reg  <= pin_s1_reg;
        pin_s3_reg  <= pin_s2_reg;
        if (!aresetn)
            pin_val_reg <= {NPINS{1'b0}};
        else
            pin_val_reg <= (pin_s2_reg & pin_s3_reg) | (pin_val_reg & (pin_s2_reg | pin_s3_reg));
    end

    // Clock gating and conversion clock tick
    wire sleep_run = sleep_mode & rc_reg;
    wire halted    = (idle_mode & sidl_reg) | (sleep_mode & ~rc_reg) | pdown_reg;
    wire active    = on_reg & ~halted;
    wire rc_edge   = rc_sync_reg[1] & rc_sync_reg[2] & ~pdown_reg;
    wire div_tick  = (tad_cnt_reg == div_reg);
    wire tad_tick  = active & (rc_reg ? rc_edge : div_tick);
    wire sleep_in  = sleep_mode & ~sleep_d_reg;

    // AXI decode
    wire wr_go     = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    wire rd_go     = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    wire wr_buf    = wr_go & ((s_axi_awaddr & `APF_BUF_MASK) == `APF_OFS_BUF);
    wire [3:0] widx = s_axi_awaddr[5:2];
    wire [3:0] ridx = s_axi_araddr[5:2];
    wire [15:0] ctrl_rd = {on_reg, 1'b0, sidl_reg, 3'h0, form_reg, 5'h00, auto_reg,
                           sample_control_reg, done_reg};
    wire [15:0] clk_rd  = {3'h0, samc_reg, rc_reg, 1'b0, div_reg};
    wire [15:0] ctrl_wr = merge16(ctrl_rd, s_axi_wdata, s_axi_wstrb);
    wire [15:0] clk_wr  = merge16(clk_rd, s_axi_wdata, s_axi_wstrb);
    wire ctrl_wen = wr_go & (s_axi_awaddr == `APF_OFS_CTRL);
    wire conv_end = tad_tick & (st_reg == ST_CONV) & (seq_cnt_reg == `APF_CONV_TADS - 5'h01);

    // Conversion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_reg        <= ST_IDLE;
            tad_cnt_reg   <= 6'h00;
            seq_cnt_reg   <= 5'h00;
            dly_reg       <= 2'h0;
            wptr_reg      <= 4'h0;
            done_reg      <= 1'b0;
            sample_control_reg      <= 1'b0;
            pdown_reg     <= 1'b0;
            sleep_d_reg   <= 1'b0;
            irq_pulse     <= 1'b0;
            wake_req      <= 1'b0;
            conv_clk      <= 1'b0;
        end else begin
            sleep_d_reg <= sleep_mode;
            irq_pulse   <= 1'b0;
            wake_req    <= 1'b0;
            tad_cnt_reg <= (!active || div_tick) ? 6'h00 : tad_cnt_reg + 6'h01;
            if (tad_tick)
                conv_clk <= ~conv_clk;
            else if (halted || !on_reg)
                conv_clk <= 1'b0;
            if (!sleep_mode)
                pdown_reg <= 1'b0;
            if (ctrl_wen)
                sample_control_reg <= ctrl_wr[`APF_SAMPLE_CONTROL_BIT];
            if (ctrl_wen && !ctrl_wr[`APF_DONE_BIT])
                done_reg <= 1'b0;
            if (!on_reg || (sleep_in && !rc_reg)) begin
                st_reg      <= ST_IDLE;
                seq_cnt_reg <= 5'h00;
            end else if (!halted) begin
                case (st_reg)
                    ST_IDLE: begin
                        if (sample_control_reg || auto_reg) begin
                            st_reg      <= ST_SAMPLE_CONTROL;
                            seq_cnt_reg <= 5'h00;
                        end
                    end
                    ST_SAMPLE_CONTROL: begin
                        if (tad_tick && seq_cnt_reg != 5'h1f)
                            seq_cnt_reg <= seq_cnt_reg + 5'h01;
                        if ((auto_reg && tad_tick && seq_cnt_reg + 5'h01 >= samc_reg) ||
                            (!auto_reg && !sample_control_reg)) begin
                            st_reg      <= rc_reg ? ST_DLY : ST_CONV;
                            dly_reg     <= 2'h0;
                            seq_cnt_reg <= 5'h00;
                        end
                    end
                    ST_DLY: begin
                        dly_reg <= dly_reg + 2'h1;
                        if (dly_reg == `APF_TCY_CYC - 1)
                            st_reg <= ST_CONV;
                    end
                    ST_CONV: begin
                        if (tad_tick)
                            seq_cnt_reg <= seq_cnt_reg + 5'h01;
                        if (conv_end) begin
                            st_reg   <= ST_IDLE;
                            wptr_reg <= wptr_reg + 4'h1;
                            if (sleep_mode) begin
                                irq_pulse <= 1'b1;
                                if (irq_enable)
                                    wake_req <= 1'b1;
                                else
                                    pdown_reg <= 1'b1;
                            end
                        end
                    end
                    default: st_reg <= ST_IDLE;
                endcase
            end
            if (conv_end && on_reg && !halted)
                done_reg <= 1'b1;
        end
    end

    // Result buffer: no reset, so its contents survive any reset
    // Software writes land right-justified; the upper six bits are dropped
    wire [15:0] buf_wr = merge16({6'h00, buf_mem[widx]}, s_axi_wdata, s_axi_wstrb);
    always @(posedge aclk) begin
        if (wr_buf)
            buf_mem[widx] <= buf_wr[9:0];
        else if (aresetn && conv_end && on_reg && !halted)
            buf_mem[wptr_reg] <= sar_result;
    end

    // Software registers; sleep never touches them
    always @(posedge aclk) begin
        if (!aresetn) begin
            on_reg    <= 1'b0;
            sidl_reg  <= 1'b0;
            auto_reg  <= 1'b0;
            form_reg  <= `APF_FMT_INT;
            samc_reg  <= 5'h00;
            rc_reg    <= 1'b0;
            div_reg   <= 6'h00;
            pcfg_reg  <= {NPINS{1'b0}};
            dir_reg   <= {NPINS{1'b1}};
            chsel_reg <= 8'h00;
        end else if (wr_go) begin
            case (s_axi_awaddr)
                `APF_OFS_CTRL: begin
                    on_reg   <= ctrl_wr[`APF_ON_BIT];
                    sidl_reg <= ctrl_wr[`APF_SIDL_BIT];
                    form_reg <= ctrl_wr[`APF_FORM_HI:`APF_FORM_LO];
                    auto_reg <= ctrl_wr[`APF_AUTO_BIT];
                end
                `APF_OFS_CLK: begin
                    samc_reg <= clk_wr[`APF_SAMC_HI:`APF_SAMC_LO];
                    rc_reg   <= clk_wr[`APF_RC_BIT];
                    div_reg  <= clk_wr[`APF_DIV_HI:`APF_DIV_LO];
                end
                `APF_OFS_PINCFG: begin
                    pcfg_reg <= s_axi_wdata[NPINS-1:0];
                    dir_reg  <= s_axi_wdata[NPINS+15:16];
                end
                `APF_OFS_CHSEL: chsel_reg <= s_axi_wdata[7:0];
                default: chsel_reg <= chsel_reg;
            endcase
        end
    end

    // Analog side controls
    always @(posedge aclk) begin
        if (!aresetn) begin
            analog_enable          <= 1'b0;
            rc_osc_enable          <= 1'b0;
            hold_capacitor_connect <= 1'b0;
        end else begin
            analog_enable          <= on_reg & ~pdown_reg;
            rc_osc_enable          <= on_reg & rc_reg & ~pdown_reg & (~sleep_mode | sleep_run);
            hold_capacitor_connect <= active & (st_reg == ST_SAMPLE_CONTROL);
        end
    end

    // AXI write channel: address and data taken together
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `APF_RESP_OK;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (s_axi_awaddr == `APF_OFS_CTRL ||
                                 s_axi_awaddr == `APF_OFS_CLK ||
                                 s_axi_awaddr == `APF_OFS_PINCFG ||
                                 s_axi_awaddr == `APF_OFS_PORT ||
                                 s_axi_awaddr == `APF_OFS_CHSEL || wr_buf) ?
                                `APF_RESP_OK : `APF_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `APF_RESP_OK;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `APF_RESP_OK;
                s_axi_rdata  <= 32'h0000_0000;
                if ((s_axi_araddr & `APF_BUF_MASK) == `APF_OFS_BUF)
                    s_axi_rdata[15:0] <= fmt_read(buf_mem[ridx], form_reg);
                else
                    case (s_axi_araddr)
                        `APF_OFS_CTRL:   s_axi_rdata[15:0] <= ctrl_rd;
                        `APF_OFS_CLK:    s_axi_rdata[15:0] <= clk_rd;
                        `APF_OFS_PINCFG: s_axi_rdata <= {{(16-NPINS){1'b0}}, dir_reg,
                                                         {(16-NPINS){1'b0}}, pcfg_reg};
                        `APF_OFS_PORT:   s_axi_rdata[NPINS-1:0] <= pin_val_reg & pcfg_reg;
                        `APF_OFS_CHSEL:  s_axi_rdata[7:0] <= chsel_reg;
                        default:         s_axi_rresp <= `APF_RESP_ERR;
                    endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* dv/apf_analog_model.sv */
// Behavioural analog core: RC oscillator and SAR result
`timescale 1ns/1ps
module apf_analog_model (
    // Clock
    input wire       aclk,
    // Requests from the block
    input wire       rc_osc_enable,
    input wire       hold_capacitor_connect,
    // Level on the selected pin
    input wire [9:0] level,
    // Answers
    output reg       rc_osc_in,
    output reg [9:0] sar_result
);
    reg [2:0] rc_cnt;
    initial begin
        rc_osc_in = 1'b0;
        sar_result = 10'h0;
        rc_cnt = 3'h0;
    end
    // Two cycles high then three low, so both late sync stages see each pulse;
    // still while not requested
    always @(posedge aclk) begin
        rc_cnt <= (rc_cnt == 3'h4 || !rc_osc_enable) ? 3'h0 : rc_cnt + 3'h1;
        rc_osc_in <= rc_osc_enable && rc_cnt <= 3'h1;
        if (hold_capacitor_connect)
            sar_result <= level;
    end
endmodule

/* dv/apf_ctrl_sva.sv */
// Assertion checker for the converter control block
`timescale 1ns/1ps
module apf_ctrl_sva (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Read channel
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    // Power state
    input wire        sleep_mode,
    input wire        irq_enable,
    // Analog side
    input wire        rc_osc_enable,
    input wire        analog_enable,
    input wire        hold_capacitor_connect,
    input wire        conv_clk,
    input wire        irq_pulse,
    input wire        wake_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire buf_rd = s_axi_araddr[7:6] == 2'b01;
    // A sleep conversion that does not wake the device
    sequence s_done_asleep;
        irq_pulse && sleep_mode && !wake_req;
    endsequence
    rst_quiet_a: assert property ($rose(aresetn) |-> !analog_enable && !conv_clk && !irq_pulse)
        else $error("analog outputs active after reset");
    power_hold_a: assert property (hold_capacitor_connect |-> analog_enable)
        else $error("sampling while unpowered");
    clk_power_a: assert property ($rose(conv_clk) |-> analog_enable)
        else $error("conversion clock while unpowered");
    sleep_clk_a: assert property (sleep_mode && !rc_osc_enable |=> !conv_clk)
        else $error("conversion clock runs in sleep");
    irq_sleep_a: assert property (irq_pulse |-> $past(sleep_mode))
        else $error("completion pulse outside sleep");
    irq_single_a: assert property (irq_pulse |=> !irq_pulse)
        else $error("completion pulse too long");
    wake_irq_a: assert property (irq_pulse |-> wake_req == $past(irq_enable))
        else $error("wake request does not follow enable");
    wake_only_a: assert property (wake_req |-> irq_pulse)
        else $error("wake request without completion");
    self_off_a: assert property (s_done_asleep |-> ##[0:1] !analog_enable)
        else $error("no power-down after sleep conversion");
    buf_width_a: assert property ($rose(s_axi_rvalid) && $past(buf_rd) |-> s_axi_rdata[31:16] == 16'h0)
        else $error("buffer read wider than 16 bits");
endmodule

bind apf_ctrl apf_ctrl_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .sleep_mode(sleep_mode), .irq_enable(irq_enable),
    .rc_osc_enable(rc_osc_enable), .analog_enable(analog_enable),
    .hold_capacitor_connect(hold_capacitor_connect), .conv_clk(conv_clk),
    .irq_pulse(irq_pulse), .wake_req(wake_req)
);

/* dv/apf_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "apf_consts.vh"
module apf_ctrl_tb;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, got;
    reg         sleep_mode, idle_mode, irq_enable;
    reg  [8:0]  pin_in, pc;
    reg  [9:0]  level;
    reg  [9:0]  dv [4];
    reg  [1:0]  bq [$];
    reg  [65:0] rq [$];
    reg  [65:0] re;
    wire        awready, wready, bvalid, arready, rvalid, rc_osc_in, analog_enable;
    wire        rc_osc_enable, hold_cap, conv_clk, irq_pulse, wake_req;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [9:0]  sar_result;
    integer     n_errors, checks, i, k, wp;

    apf_ctrl dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .irq_enable(irq_enable),
        .pin_in(pin_in), .rc_osc_in(rc_osc_in), .sar_result(sar_result),
        .analog_enable(analog_enable), .rc_osc_enable(rc_osc_enable),
        .hold_capacitor_connect(hold_cap), .conv_clk(conv_clk), .irq_pulse(irq_pulse),
        .wake_req(wake_req)
    );
    apf_analog_model u_ana (
        .aclk(aclk), .rc_osc_enable(rc_osc_enable), .hold_capacitor_connect(hold_cap),
        .level(level), .rc_osc_in(rc_osc_in), .sar_result(sar_result)
    );

    always #2 aclk = ~aclk;

    function automatic [15:0] fmt(input [9:0] d, input [1:0] f);
        case (f)
            `APF_FMT_INT:  fmt = {6'h0, d};
            `APF_FMT_SINT: fmt = {{6{d[9]}}, d};
            default:       fmt = {d, 6'h0};
        endcase
    endfunction
    task automatic cmp(input [31:0] exp, input [31:0] seen, input string what);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
        rq.push_back({m, e, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        got = rdata;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Sample, then end sampling by software, optionally entering sleep at once
    task automatic conv(input [15:0] clk, input sl);
        level <= 10'($urandom);
        wr(8'h04, {16'h0, clk}, 2'h0);
        wr(8'h00, 32'h8002, 2'h0);
        repeat (6) @(posedge aclk);
        wr(8'h00, 32'h8000, 2'h0);
        sleep_mode <= sl;
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Result watcher: oldest note against each response
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready === 1'b1)
            cmp({30'h0, bq.pop_front()}, {30'h0, bresp}, "bresp");
        if (rvalid === 1'b1 && rready === 1'b1) begin
            re = rq.pop_front();
            cmp({30'h0, re[1:0]}, {30'h0, rresp}, "rresp");
            cmp(re[33:2] & re[65:34], rdata & re[65:34], "rdata");
        end
    end

    initial begin
        #100000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata, sleep_mode, idle_mode, irq_enable} = 51'h0;
        pin_in = 9'h0;
        level = 10'h0;
        n_errors = 0;
        checks = 0;
        wp = 1;
        void'($urandom(32'h7cf3a194));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0, 32'hffffffff, 2'h0);
        rd(8'h04, 32'h0, 32'hffffffff, 2'h0);
        rd(8'h08, 32'h01ff0000, 32'hffffffff, 2'h0);
        $display("test reset values done");
        for (k = 0; k < 4; k = k + 1) begin
            dv[k] = 10'($urandom);
            wr(8'h00, {22'h0, k[1:0], 8'h0}, 2'h0);
            wr(8'(8'h40 + 4 * k), {22'h0, dv[k]}, 2'h0);
            for (i = 0; i < 4; i = i + 1) begin
                wr(8'h00, {22'h0, i[1:0], 8'h0}, 2'h0);
                rd(8'(8'h40 + 4 * k), {16'h0, fmt(dv[k], i[1:0])}, 32'hffffffff, 2'h0);
            end
        end
        $display("test formats done");
        rd(8'h20, 32'h0, 32'hffffffff, `APF_RESP_ERR);
        wr(8'h20, 32'hffff, `APF_RESP_ERR);
        pc = 9'($urandom);
        pin_in <= 9'($urandom);
        wr(8'h08, {7'h0, 9'($urandom), 7'h0, pc}, 2'h0);
        repeat (5) @(posedge aclk);
        rd(8'h0c, {23'h0, pin_in & pc}, 32'hffffffff, 2'h0);
        wr(8'h0c, 32'h0, 2'h0);
        $display("test pins done");
        wr(8'h10, $urandom, 2'h0);
        wr(8'h00, 32'h8000, 2'h0);
        repeat (10) @(posedge aclk);
        conv(16'h0001, 1'b0);
        k = 0;
        do begin
            rd(8'h00, 32'h0, 32'h0, 2'h0);
            k = k + 1;
        end while (got[0] !== 1'b1 && k < 40);
        cmp(32'h1, {31'h0, got[0]}, "done");
        rd(8'h40, {22'h0, level}, 32'hffffffff, 2'h0);
        $display("test manual conversion done");
        level <= 10'($urandom);
        wr(8'h00, 32'ha002, 2'h0);
        repeat (6) @(posedge aclk);
        idle_mode <= 1'b1;
        wr(8'h00, 32'ha000, 2'h0);
        repeat (60) @(posedge aclk);
        rd(8'h00, 32'ha000, 32'ha001, 2'h0);
        idle_mode <= 1'b0;
        repeat (60) @(posedge aclk);
        rd(8'h00, 32'ha001, 32'ha001, 2'h0);
        rd(8'h44, {22'h0, level}, 32'hffffffff, 2'h0);
        $display("test idle stop done");
        for (i = 0; i < 2; i = i + 1) begin
            irq_enable <= i[0];
            conv(16'h0080, 1'b1);
            k = 0;
            while (irq_pulse !== 1'b1 && k < 400) begin
                @(posedge aclk);
                k = k + 1;
            end
            cmp({30'h0, 1'b1, i[0]}, {30'h0, irq_pulse, wake_req}, "irq_wake");
            repeat (2) @(posedge aclk);
            cmp({31'h0, i[0]}, {31'h0, analog_enable}, "analog_enable");
            cmp({31'h0, i[0]}, {31'h0, rc_osc_enable}, "rc_osc_enable");
            sleep_mode <= 1'b0;
            @(posedge aclk);
            rd(8'h00, 32'h8001, 32'h8001, 2'h0);
            wp = wp + 1;
            rd(8'(8'h40 + 4 * wp), {22'h0, level}, 32'hffffffff, 2'h0);
        end
        $display("test sleep conversion done");
        wr(8'h50, {22'h0, dv[3]}, 2'h0);
        conv(16'h0003, 1'b1);
        repeat (150) @(posedge aclk);
        sleep_mode <= 1'b0;
        repeat (150) @(posedge aclk);
        rd(8'h00, 32'h8000, 32'h8001, 2'h0);
        rd(8'h50, {22'h0, dv[3]}, 32'hffffffff, 2'h0);
        $display("test sleep abort done");
        conv(16'h0001, 1'b0);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0, 32'hffffffff, 2'h0);
        rd(8'h50, {22'h0, dv[3]}, 32'hffffffff, 2'h0);
        $display("test reset abort done");
        level <= 10'($urandom);
        wr(8'h04, 32'h0101, 2'h0);
        wr(8'h00, 32'h8004, 2'h0);
        repeat (100) @(posedge aclk);
        rd(8'h00, 32'h8005, 32'hffffffff, 2'h0);
        rd(8'h40, {22'h0, level}, 32'hffffffff, 2'h0);
        $display("test auto sampling done");
        tally_and_finish;
    end
endmodule
